// ### hw/apc_top.sv
// Asynchronous peripheral configuration write port, top level

// Function
// [R01] Byte latched at trailing edge of write strobe, chip selects, read high.
// [R02] Accepted byte double-buffered, then shifted serially into configuration.
// [R03] Preamble and overflow bits appear on the serial output.
// [R04] Ready/busy low on receipt, high once buffer moved to shifter.
// [R05] Host may start next write as soon as ready/busy falls.
// [R06] Host holds write until ready/busy high for one clock period.
// [R07] Ready/busy only weakly pulled high before init rises.
// [R08] Busy lasts two config clock periods when shifter empty.
// [R09] Busy may last up to nine periods when shifter still full.
// [R10] Last byte: seven bits shifted, clock high, output at bit six.
// [R11] Host may skip handshake if writes are over ten periods apart.
// [R12] Init is open-drain, only ever pulled low.
// [R13] Mode pins must present 101 to select this mode.
// [R14] Status read: bit 7 ready, bits 0 to 6 high.
// [R15] Host must complete whole start-up within one byte write.
module apc_top #(
    parameter int CONFIG_CLOCK_HALF  = apc_pkg::CONFIG_CLOCK_HALF_CYCLES,
    parameter int INIT_CLEAR = apc_pkg::INIT_CLEAR_CYCLES,
    parameter int FIFO_DEPTH = apc_pkg::FIFO_DEPTH
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_n,
    input  wire logic       write_strobe_n,
    input  wire logic       chip_select_low_n,
    input  wire logic       chip_select_high,
    input  wire logic       read_strobe_n,
    input  wire logic [2:0] mode_select_pins,
    input  wire logic       init_in,
    output logic            init_out,
    output logic            init_oe_n,
    output logic            rdy_busy_out,
    output logic            rdy_busy_oe_n,
    output logic            config_clock,
    output logic            serial_out,
    output logic            cfg_bit,
    output logic            cfg_bit_valid,
    input  wire logic       cfg_own_full
);
    // Synchronised pin bundle layout
    localparam int PW = 16;

    typedef struct packed {
        apc_pkg::apc_phase_t phase;
        logic [PW-1:0]       s1;
        logic [PW-1:0]       s2;
        logic [15:0]         init_cnt;
        logic                wr_act;
        logic [7:0]          wr_data;
        logic                cap_valid;
        logic [7:0]          cap_data;
        logic [15:0]         div_cnt;
        logic                half_tick;
        logic                tick_phase;
        logic                busy;
        logic [3:0]          busy_cnt;
        logic [7:0]          dout;
        logic                doe_n;
        logic                init_oe_n;
        logic                rdy_oe_n;
        logic                rdy;
    } apc_top_state_t;

    apc_top_state_t st;
    apc_top_state_t next_st;
    logic [1:0]     rst_q;
    logic           rst_n_sync;

    logic [7:0] p_data;
    logic       p_ws_n;
    logic       p_cs0_n;
    logic       p_cs1;
    logic       p_rs_n;
    logic [2:0] p_mode;
    logic       p_init;
    logic       wr_cond;
    logic       rd_cond;
    logic       period_tick;
    logic       shifter_full;
    logic       shift_tick;

    apc_byte_if #(.W(apc_pkg::BYTE_BITS)) cap_q ();
    apc_byte_if #(.W(apc_pkg::BYTE_BITS)) hold_q ();

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_q <= 2'h0;
        end
        else
        begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_q[1];

    assign {p_data, p_ws_n, p_cs0_n, p_cs1, p_rs_n, p_mode, p_init} = st.s2;

    // Write and status decode from synchronised pins
    assign wr_cond = !p_ws_n && !p_cs0_n && p_rs_n && p_cs1;
    assign rd_cond = p_ws_n && !p_cs0_n && p_cs1 && !p_rs_n;
    assign period_tick = st.half_tick && st.tick_phase;
    assign shift_tick  = st.half_tick && (st.phase == apc_pkg::APC_ACTIVE);

    assign cap_q.valid = st.cap_valid;
    assign cap_q.data  = st.cap_data;

    assign data_out      = st.dout;
    assign data_oe_n     = st.doe_n;
    assign init_out      = 1'b0; // [R12]
    assign init_oe_n     = st.init_oe_n;
    assign rdy_busy_out  = st.rdy;
    assign rdy_busy_oe_n = st.rdy_oe_n;

    apc_fifo #(
        .WIDTH (apc_pkg::BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock      (clock),
        .rst_n_sync (rst_n_sync),
        .fill       (cap_q.snk),
        .drain      (hold_q.src)
    );

    apc_shifter u_shift (
        .clock         (clock),
        .rst_n_sync    (rst_n_sync),
        .half_tick     (shift_tick),
        .own_full      (cfg_own_full),
        .load          (hold_q.snk),
        .cfg_clock     (config_clock),
        .serial_out    (serial_out), // [R03]
        .cfg_bit       (cfg_bit),
        .cfg_bit_valid (cfg_bit_valid),
        .holding       (shifter_full)
    );

    always_comb
    begin
        next_st = st;
        next_st.s1 = {data_in, write_strobe_n, chip_select_low_n,
                      chip_select_high, read_strobe_n,
                      mode_select_pins, init_in};
        next_st.s2 = st.s1;

        // Half-period divider for the configuration clock
        next_st.half_tick = 1'b0;
        if (st.div_cnt == 16'(CONFIG_CLOCK_HALF - 1))
        begin
            next_st.div_cnt    = '0;
            next_st.half_tick  = 1'b1;
        end
        else
        begin
            next_st.div_cnt = st.div_cnt + 1'b1;
        end
        if (st.half_tick)
        begin
            next_st.tick_phase = !st.tick_phase;
        end

        unique case (st.phase)
            apc_pkg::APC_CLEAR:
            begin
                next_st.init_oe_n = 1'b0; // [R12]
                if (st.init_cnt == 16'(INIT_CLEAR - 1))
                begin
                    next_st.init_oe_n = 1'b1;
                    next_st.phase     = apc_pkg::APC_WAIT_INIT;
                end
                else
                begin
                    next_st.init_cnt = st.init_cnt + 1'b1;
                end
            end
            apc_pkg::APC_WAIT_INIT:
            begin
                next_st.rdy_oe_n = 1'b1; // [R07]
                if (p_init && p_mode == apc_pkg::MODE_ASYNC_PERIPH) // [R13]
                begin
                    next_st.phase = apc_pkg::APC_ACTIVE;
                end
            end
            apc_pkg::APC_ACTIVE:
            begin
                next_st.rdy_oe_n = 1'b0;
            end
            default:
            begin
                next_st.phase = apc_pkg::APC_CLEAR;
            end
        endcase

        // Capture window data, latch on the trailing edge
        next_st.wr_act = wr_cond;
        if (wr_cond)
        begin
            next_st.wr_data = p_data;
        end

        // Hand the captured byte to the FIFO
        if (st.cap_valid && cap_q.ready)
        begin
            next_st.cap_valid = 1'b0;
        end

        // Busy span: minimum two periods, ends when buffer drained
        if (st.busy && period_tick &&
            st.busy_cnt != apc_pkg::BUSY_MAX_PERIODS)
        begin
            next_st.busy_cnt = st.busy_cnt + 1'b1; // [R09]
        end
        if (st.busy && !st.cap_valid && !hold_q.valid &&
            st.busy_cnt >= apc_pkg::BUSY_MIN_PERIODS) // [R08]
        begin
            next_st.busy = 1'b0; // [R04]
        end

        // New byte: set wins over a clear in the same cycle
        if (st.wr_act && !wr_cond &&
            st.phase == apc_pkg::APC_ACTIVE && !st.cap_valid)
        begin
            next_st.cap_valid = 1'b1; // [R01]
            next_st.cap_data  = st.wr_data;
            next_st.busy      = 1'b1; // [R04]
            next_st.busy_cnt  = '0;
        end

        next_st.rdy = (next_st.phase == apc_pkg::APC_ACTIVE) ?
                      !next_st.busy : 1'b1;

        // Status onto the data bus
        next_st.doe_n = !(rd_cond && st.phase == apc_pkg::APC_ACTIVE);
        next_st.dout  = {!st.busy, apc_pkg::STATUS_FILL}; // [R14]
    end

    always_ff @(posedge clock or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st           <= '0;
            st.phase     <= apc_pkg::APC_CLEAR;
            st.init_oe_n <= 1'b0;
            st.rdy_oe_n  <= 1'b1;
            st.rdy       <= 1'b1;
            st.doe_n     <= 1'b1;
            st.s1        <= '1;
            st.s2        <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ### hw/apc_pkg.sv
// Constants and types of the asynchronous peripheral configuration port
package apc_pkg;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int CONFIG_CLOCK_PERIOD_NS   = 1000;
    localparam int CONFIG_CLOCK_HALF_CYCLES =
        CONFIG_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int INIT_CLEAR_NS     = 2000;
    localparam int INIT_CLEAR_CYCLES =
        (INIT_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
    localparam logic [6:0] STATUS_FILL       = 7'h7F;
    localparam logic [3:0] BUSY_MIN_PERIODS  = 4'h2;
    localparam logic [3:0] BUSY_MAX_PERIODS  = 4'h9;
    localparam logic [2:0] STALL_BIT         = 3'h6;
    localparam logic [2:0] LAST_BIT          = 3'h7;
    localparam int BYTE_BITS  = 8;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        APC_SH_IDLE = 2'b00,
        APC_SH_LOW  = 2'b01,
        APC_SH_HIGH = 2'b10
    } apc_shift_state_t;

    typedef enum logic [1:0] {
        APC_CLEAR     = 2'b00,
        APC_WAIT_INIT = 2'b01,
        APC_ACTIVE    = 2'b10
    } apc_phase_t;
endpackage

// ### hw/apc_byte_if.sv
// Byte stream carrier between the port's own modules
interface apc_byte_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### hw/apc_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
module apc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic clock,
    input  wire logic rst_n_sync,
    apc_byte_if.snk   fill,
    apc_byte_if.src   drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [CW-1:0]               count;
    } apc_fifo_state_t;

    apc_fifo_state_t st;
    apc_fifo_state_t next_st;
    logic            push;
    logic            pop;

    assign fill.ready  = (st.count != CW'(DEPTH));
    assign drain.valid = (st.count != '0);
    assign drain.data  = st.mem[st.rd];

    always_comb
    begin
        next_st = st;
        push    = fill.valid && fill.ready;
        pop     = drain.valid && drain.ready;
        if (push)
        begin
            next_st.mem[st.wr] = fill.data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop)
        begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        if (push && !pop)
        begin
            next_st.count = st.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ### hw/apc_shifter.sv
// Parallel-to-serial shift stage driving the configuration clock
module apc_shifter (
    input  wire logic clock,
    input  wire logic rst_n_sync,
    input  wire logic half_tick,
    input  wire logic own_full,
    apc_byte_if.snk   load,
    output logic      cfg_clock,
    output logic      serial_out,
    output logic      cfg_bit,
    output logic      cfg_bit_valid,
    output logic      holding
);
    typedef struct packed {
        apc_pkg::apc_shift_state_t sm;
        logic [7:0]                sr;
        logic [2:0]                idx;
        logic                      full;
        logic                      clk;
        logic                      dout;
        logic                      bitv;
    } apc_shift_reg_t;

    apc_shift_reg_t st;
    apc_shift_reg_t next_st;

    // Take a byte only when empty or when the last bit has gone
    assign load.ready = half_tick &&
        ((st.sm == apc_pkg::APC_SH_IDLE && !st.full) ||
         (st.sm == apc_pkg::APC_SH_HIGH && st.idx == apc_pkg::LAST_BIT));
    assign cfg_clock     = st.clk;
    assign serial_out    = st.dout;
    assign cfg_bit       = st.dout;
    assign cfg_bit_valid = st.bitv;
    assign holding       = st.full;

    always_comb
    begin
        next_st      = st;
        next_st.bitv = 1'b0;
        if (half_tick)
        begin
            unique case (st.sm)
                apc_pkg::APC_SH_IDLE:
                begin
                    if (load.valid && !st.full)
                    begin
                        next_st.sr   = load.data; // [R02]
                        next_st.full = 1'b1;
                        next_st.idx  = '0;
                        next_st.dout = load.data[0];
                        next_st.clk  = 1'b0;
                        next_st.sm   = apc_pkg::APC_SH_LOW;
                    end
                    else if (load.valid)
                    begin
                        next_st.idx  = apc_pkg::LAST_BIT;
                        next_st.dout = st.sr[apc_pkg::LAST_BIT];
                        next_st.clk  = 1'b0;
                        next_st.sm   = apc_pkg::APC_SH_LOW;
                    end
                end
                apc_pkg::APC_SH_LOW:
                begin
                    next_st.clk  = 1'b1;
                    next_st.bitv = !own_full; // [R03]
                    next_st.sm   = apc_pkg::APC_SH_HIGH;
                end
                apc_pkg::APC_SH_HIGH:
                begin
                    if (st.idx == apc_pkg::LAST_BIT && load.valid)
                    begin
                        next_st.sr   = load.data; // [R02]
                        next_st.idx  = '0;
                        next_st.dout = load.data[0];
                        next_st.clk  = 1'b0;
                        next_st.sm   = apc_pkg::APC_SH_LOW;
                    end
                    else if (st.idx == apc_pkg::LAST_BIT)
                    begin
                        next_st.full = 1'b0;
                        next_st.sm   = apc_pkg::APC_SH_IDLE;
                    end
                    else if (st.idx == apc_pkg::STALL_BIT && !load.valid)
                    begin
                        next_st.sm = apc_pkg::APC_SH_IDLE; // [R10]
                    end
                    else
                    begin
                        next_st.idx  = st.idx + 1'b1;
                        next_st.dout = st.sr[st.idx + 1'b1];
                        next_st.clk  = 1'b0;
                        next_st.sm   = apc_pkg::APC_SH_LOW;
                    end
                end
                default:
                begin
                    next_st.sm = apc_pkg::APC_SH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st     <= '0;
            st.clk <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ### tb/apc_top_chk.sv
// Pin-level assertions for the configuration port
module apc_top_chk #(
    parameter int CONFIG_CLOCK_HALF = 2
) (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_n,
    input wire logic       write_strobe_n,
    input wire logic       chip_select_low_n,
    input wire logic       chip_select_high,
    input wire logic       read_strobe_n,
    input wire logic       init_in,
    input wire logic       init_out,
    input wire logic       init_oe_n,
    input wire logic       rdy_busy_out,
    input wire logic       rdy_busy_oe_n,
    input wire logic       config_clock,
    input wire logic       serial_out,
    input wire logic       cfg_bit_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ten periods plus sync slack
    localparam int BUSY_MAX = 20 * CONFIG_CLOCK_HALF + 4;
    logic wr_c;
    logic rd_c;
    assign wr_c = !write_strobe_n && !chip_select_low_n
        && chip_select_high && read_strobe_n;
    assign rd_c = write_strobe_n && !chip_select_low_n
        && chip_select_high && !read_strobe_n;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr_end;
        $fell(wr_c) && !rdy_busy_oe_n;
    endsequence
    sequence s_rd_held;
        (rd_c && !rdy_busy_oe_n)[*5];
    endsequence
    init_od_a: assert property (!init_oe_n |-> !init_out)
        else $error("init driven high");
    rdy_weak_a: assert property ((!init_in)[*4] |-> rdy_busy_oe_n)
        else $error("ready driven early");
    busy_fall_a: assert property (s_wr_end |-> ##[3:5] !rdy_busy_out)
        else $error("no busy after write");
    busy_min_a: assert property ($fell(rdy_busy_out) |-> !rdy_busy_out[*4])
        else $error("busy too short");
    busy_max_a: assert property ($fell(rdy_busy_out)
        |-> ##[1:BUSY_MAX] (rdy_busy_out || wr_c))
        else $error("busy too long");
    bit_pulse_a: assert property (cfg_bit_valid
        |=> !cfg_bit_valid && config_clock)
        else $error("bad bit pulse");
    dout_hold_a: assert property (config_clock && $past(config_clock)
        |-> $stable(serial_out))
        else $error("serial moved while clock high");
    stat_fill_a: assert property (s_rd_held
        |-> !data_oe_n && data_out[6:0] == apc_pkg::STATUS_FILL)
        else $error("bad status");
    stat_off_a: assert property ((!rd_c)[*5] |-> data_oe_n)
        else $error("bus driven without read");
endmodule

// ### tb/apc_host.sv
// Host processor model writing configuration bytes
module apc_host #(
    parameter int PERIOD = 4
) (
    input  wire logic       clock,
    input  wire logic       rdy_busy_out,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output logic      [7:0] data_in,
    output logic            write_strobe_n,
    output logic            chip_select_low_n,
    output logic            chip_select_high,
    output logic            read_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        data_in = 8'h00;
        write_strobe_n = 1'b1;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        read_strobe_n = 1'b1;
    end
    // Whole byte in one strobe, no wait for ready first
    task automatic write_byte(input logic [7:0] b, input bit hs);
        int ok;
        ok = 0;
        @(negedge clock);
        data_in = b;
        write_strobe_n = 1'b0;
        chip_select_low_n = 1'b0;
        chip_select_high = 1'b1;
        // Hold until ready high one period
        for (int i = 0; i < 200 && (i < 3 || (hs && ok < PERIOD)); i++)
        begin
            @(negedge clock);
            ok = rdy_busy_out ? ok + 1 : 0;
        end
        write_strobe_n = 1'b1;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        @(negedge clock);
        data_in = ~b;
    endtask
    task automatic read_status(output logic [7:0] d, output logic on_n,
                               output logic off_n);
        @(negedge clock);
        read_strobe_n = 1'b0;
        chip_select_low_n = 1'b0;
        chip_select_high = 1'b1;
        repeat (6) @(negedge clock);
        d = data_out;
        on_n = data_oe_n;
        read_strobe_n = 1'b1;
        chip_select_low_n = 1'b1;
        chip_select_high = 1'b0;
        repeat (6) @(negedge clock);
        off_n = data_oe_n;
    endtask
endmodule

// ### tb/test_apc_top.sv
// Self-checking bench for the configuration port
module test_apc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock;
    logic       rst_b;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe_n;
    logic       write_strobe_n;
    logic       chip_select_low_n;
    logic       chip_select_high;
    logic       read_strobe_n;
    logic [2:0] mode_select_pins;
    logic       init_in;
    logic       init_out;
    logic       init_oe_n;
    logic       rdy_busy_out;
    logic       rdy_busy_oe_n;
    logic       config_clock;
    logic       serial_out;
    logic       cfg_bit;
    logic       cfg_bit_valid;
    logic       cfg_own_full;
    logic       prev_config_clock = 1'b1;
    logic       got[$];
    logic [7:0] sent[$];
    int         n_valid = 0;
    int         mismatches = 0;
    int         n_tests = 0;
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Init wire pulled up unless pulled low
    assign init_in = init_oe_n ? 1'b1 : init_out;
    apc_top #(
        .CONFIG_CLOCK_HALF  (2),
        .INIT_CLEAR (4)
    ) i_apc_top (
        .clock (clock), .rst_b (rst_b), .data_in (data_in),
        .data_out (data_out), .data_oe_n (data_oe_n),
        .write_strobe_n (write_strobe_n),
        .chip_select_low_n (chip_select_low_n),
        .chip_select_high (chip_select_high),
        .read_strobe_n (read_strobe_n),
        .mode_select_pins (mode_select_pins), .init_in (init_in),
        .init_out (init_out), .init_oe_n (init_oe_n),
        .rdy_busy_out (rdy_busy_out), .rdy_busy_oe_n (rdy_busy_oe_n),
        .config_clock (config_clock), .serial_out (serial_out),
        .cfg_bit (cfg_bit), .cfg_bit_valid (cfg_bit_valid),
        .cfg_own_full (cfg_own_full)
    );
    apc_host i_apc_host (
        .clock (clock), .rdy_busy_out (rdy_busy_out),
        .data_out (data_out), .data_oe_n (data_oe_n), .data_in (data_in),
        .write_strobe_n (write_strobe_n),
        .chip_select_low_n (chip_select_low_n),
        .chip_select_high (chip_select_high),
        .read_strobe_n (read_strobe_n)
    );
    // Serial bit taken at each config clock rise
    always @(posedge clock)
    begin
        prev_config_clock <= config_clock;
        if (rst_b && config_clock && !prev_config_clock)
            got.push_back(serial_out);
        if (cfg_bit_valid)
            n_valid++;
    end
    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] want);
        n_tests++;
        if (seen !== want)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic give_up();
        check("timeout", 16'h0, 16'h1);
        print_verdict();
    endtask
    function automatic logic sig(input int sel);
        case (sel)
            0:       return rdy_busy_out;
            1:       return rdy_busy_oe_n;
            default: return init_oe_n;
        endcase
    endfunction
    task automatic wait_sig(input int sel, input logic lvl, output int n);
        n = 0;
        while (sig(sel) !== lvl)
        begin
            @(negedge clock);
            n++;
            if (n > 64)
                give_up();
        end
    endtask
    task automatic check_stream();
        int nb;
        int k;
        nb = sent.size() * 8 - 1;
        k = 0;
        while (got.size() < nb)
        begin
            @(negedge clock);
            k++;
            if (k > 4000)
                give_up();
        end
        repeat (40) @(negedge clock);
        check("bit count", 16'(got.size()), 16'(nb));
        for (int i = 0; i < nb; i++)
            check("bit", got[i], sent[i / 8][i % 8]);
        check("stall bit", serial_out, sent[$][6]);
        check("stall clock", config_clock, 1'b1);
    endtask
    task automatic t_start();
        int n;
        @(negedge clock);
        rst_b = 1'b0;
        mode_select_pins = 3'h0;
        repeat (6) @(negedge clock);
        got.delete();
        sent.delete();
        rst_b = 1'b1;
        check("init pull", init_oe_n, 1'b0);
        wait_sig(2, 1'b1, n);
        repeat (20) @(negedge clock);
        check("rdy undriven", rdy_busy_oe_n, 1'b1);
        check("idle clock", config_clock, 1'b1);
        mode_select_pins = apc_pkg::MODE_ASYNC_PERIPH;
        wait_sig(1, 1'b0, n);
        check("rdy ready", rdy_busy_out, 1'b1);
    endtask
    task automatic t_read(input logic [7:0] want);
        logic [7:0] d;
        logic       on_n;
        logic       off_n;
        i_apc_host.read_status(d, on_n, off_n);
        check("status", d, want);
        check("status on", on_n, 1'b0);
        check("status off", off_n, 1'b1);
    endtask
    task automatic t_hs();
        int n;
        int v0;
        v0 = n_valid;
        i_apc_host.write_byte(8'hA5, 1'b1);
        sent.push_back(8'hA5);
        wait_sig(0, 1'b0, n);
        check("busy fall", 16'(n <= 5), 16'h1);
        wait_sig(0, 1'b1, n);
        check("busy short", 16'(n <= 10), 16'h1);
        i_apc_host.write_byte(8'h3C, 1'b1);
        sent.push_back(8'h3C);
        wait_sig(0, 1'b0, n);
        i_apc_host.write_byte(8'h0F, 1'b1);
        sent.push_back(8'h0F);
        wait_sig(0, 1'b0, n);
        t_read(8'h7F);
        wait_sig(0, 1'b1, n);
        check("busy long", 16'(n <= 40), 16'h1);
        check_stream();
        check("pulses", 16'(n_valid - v0), 16'h17);
    endtask
    task automatic t_burst();
        logic [7:0] burst[4] = '{8'h01, 8'h80, 8'hFF, 8'h00};
        int v0;
        cfg_own_full = 1'b1;
        v0 = n_valid;
        foreach (burst[i])
        begin
            i_apc_host.write_byte(burst[i], 1'b0);
            sent.push_back(burst[i]);
        end
        check_stream();
        check("masked", 16'(n_valid - v0), 16'h0);
        cfg_own_full = 1'b0;
        i_apc_host.write_byte(8'h5A, 1'b0);
        sent.push_back(8'h5A);
        repeat (48) @(negedge clock);
        i_apc_host.write_byte(8'hC3, 1'b0);
        sent.push_back(8'hC3);
        check_stream();
    endtask
    initial
    begin
        rst_b = 1'b0;
        mode_select_pins = 3'h0;
        cfg_own_full = 1'b0;
        t_start();
        t_read(8'hFF);
        t_hs();
        t_burst();
        t_start();
        print_verdict();
    end
endmodule
bind apc_top apc_top_chk #(
    .CONFIG_CLOCK_HALF (CONFIG_CLOCK_HALF)
) i_apc_top_chk (
    .clock (clock), .rst_b (rst_b), .data_out (data_out),
    .data_oe_n (data_oe_n), .write_strobe_n (write_strobe_n),
    .chip_select_low_n (chip_select_low_n),
    .chip_select_high (chip_select_high),
    .read_strobe_n (read_strobe_n), .init_in (init_in),
    .init_out (init_out), .init_oe_n (init_oe_n),
    .rdy_busy_out (rdy_busy_out), .rdy_busy_oe_n (rdy_busy_oe_n),
    .config_clock (config_clock), .serial_out (serial_out),
    .cfg_bit_valid (cfg_bit_valid)
);
